// ### verilog/lsg_pkg.sv
// constants shared by the led sink gain and error scan block
package lsg_pkg;
   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_SCAN = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_OUT_LATCH = 8'h14;
   localparam int unsigned ADDR_BITS = 8;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int unsigned CTRL_SPECIAL_BIT = 0;
   localparam int unsigned CFG_MULT_BIT = 0;
   localparam int unsigned CFG_EXP_BIT = 1;
   localparam int unsigned CFG_MANT_LSB = 2;
   localparam int unsigned CFG_MANT_W = 6;
   localparam logic [7:0] CFG_RESET = 8'hff;
   localparam int unsigned EVT_CFG_WRITTEN = 0;
   localparam int unsigned EVT_CAPTURED = 1;
   localparam int unsigned EVT_FAULT = 2;
   localparam int unsigned EVT_EARLY = 3;
   localparam int unsigned EVT_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // gain arithmetic
   // ------------------------------------------------------------
   localparam logic [3:0] RATIO_HIGH = 4'hf;
   localparam logic [3:0] RATIO_LOW = 4'h5;
   localparam logic [6:0] MANT_OFFSET = 7'h40;
   localparam logic [9:0] GAIN_DEN_HIGH = 10'h100;
   localparam logic [9:0] GAIN_DEN_LOW = 10'h300;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SETTLE_NS = 2000;
   localparam int unsigned SETTLE_CYC =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SWITCH_PULSES = 2;

   typedef enum logic [1:0] {
      DET_IDLE = 2'b00,
      DET_SWITCH = 2'b01,
      DET_SETTLE = 2'b10,
      DET_DONE = 2'b11
   } lsg_det_type;
endpackage : lsg_pkg

// ### verilog/lsg_cfg_if.sv
// configuration code and derived gain between latch and gain stage
interface lsg_cfg_if;
   logic [7:0] cfg_code;
   logic [3:0] current_ratio;
   logic [7:0] gain_num;
   logic [9:0] gain_den;

   modport latch (output cfg_code, input current_ratio, gain_num, gain_den);
   modport gain (input cfg_code, output current_ratio, gain_num, gain_den);
endinterface : lsg_cfg_if

// ### verilog/lsg_gain.sv
// current ratio and total current gain from the configuration code
module lsg_gain (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   lsg_cfg_if.gain cfg
);
   // ------------------------------------------------------------
   // arithmetic
   // ------------------------------------------------------------
   // gain = (1+exp)*(64+mant)/256 * 3^(mult-1), kept as num/den
   // the lowest mantissa bit of the code carries the heaviest weight
   function automatic logic [7:0] gain_numerator(input logic [7:0] code);
      logic [6:0] base;
      logic [5:0] mant;
      for (int i = 0; i < lsg_pkg::CFG_MANT_W; i++) begin
         mant[lsg_pkg::CFG_MANT_W-1-i] = code[lsg_pkg::CFG_MANT_LSB+i];
      end
      base = lsg_pkg::MANT_OFFSET + {1'b0, mant};
      gain_numerator = code[lsg_pkg::CFG_EXP_BIT] ? {base, 1'b0}
                                                  : {1'b0, base};
   endfunction : gain_numerator

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg.current_ratio <= lsg_pkg::RATIO_HIGH;
         cfg.gain_num <= 8'hfe;
         cfg.gain_den <= lsg_pkg::GAIN_DEN_HIGH;
      end else if (ce) begin
         if (cfg.cfg_code[lsg_pkg::CFG_MULT_BIT]) begin
            cfg.current_ratio <= lsg_pkg::RATIO_HIGH;
            cfg.gain_den <= lsg_pkg::GAIN_DEN_HIGH;
         end else begin
            cfg.current_ratio <= lsg_pkg::RATIO_LOW;
            cfg.gain_den <= lsg_pkg::GAIN_DEN_LOW;
         end
         cfg.gain_num <= gain_numerator(cfg.cfg_code);
      end
   end
endmodule : lsg_gain

// ### verilog/lsg_top.sv
// special-mode gain configuration and led error scan with axi4-lite regs
//
// Operation
// - multiplier bit one selects output to reference current ratio fifteen.
// - multiplier bit zero selects output to reference current ratio five.
// - total gain is voltage gain times three to (multiplier minus one).
// - after reset the configuration code is all ones.
// - serial out feeds next device; clock, latch, enable lines shared.
// - two clocks with enable low switch shift input to comparators.
// - third clock rising edge loads channel status into shift register.
// - after enable rises, each clock shifts status out and data in.
// - a failing channel reads zero in place of its image one.
// - in special mode latch pulse loads configuration, not output latch.
// - bit seven shifts in first; bit0 multiplier, bit1 exponent, 2-7 mantissa.
// - enabled channel at threshold reads one; below or disabled reads zero.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
module lsg_top #(
   parameter int unsigned CHANNELS = 8,
   parameter int unsigned SYNC_STAGES = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // serial chain pins
   input wire logic serial_clk,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic latch_mode_pin,
   input wire logic enable_switch_detect_pin_n,
   // channel side
   input wire logic [7:0] channel_current_ok,
   output logic [7:0] channel_drive,
   output logic [3:0] current_ratio,
   output logic [7:0] gain_num,
   output logic [9:0] gain_den,
   output logic irq
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (CHANNELS != 8) begin : g_bad_channels
      $error("lsg_top serves exactly eight channels");
   end
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("lsg_top needs at least two synchroniser stages");
   end
   if (lsg_pkg::SETTLE_CYC > 255) begin : g_bad_settle
      $error("settle count does not fit its counter");
   end

   function automatic logic rose(input logic prev, input logic cur);
      rose = cur & ~prev;
   endfunction : rose

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int unsigned PIN_W = 12;
   logic [PIN_W-1:0] pin_sync [SYNC_STAGES];
   logic [PIN_W-1:0] pin_now;
   logic sclk_prev;
   logic latch_prev;
   logic ed_prev_n;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            pin_sync[i] <= '0;
         end
      end else if (ce) begin
         pin_sync[0] <= {channel_current_ok, enable_switch_detect_pin_n,
                         latch_mode_pin, serial_in, serial_clk};
         for (int i = 1; i < SYNC_STAGES; i++) begin
            pin_sync[i] <= pin_sync[i-1];
         end
      end
   end

   assign pin_now = pin_sync[SYNC_STAGES-1];

   logic sclk_s;
   logic sin_s;
   logic latch_s;
   logic ed_s_n;
   logic [7:0] ok_s;
   assign sclk_s = pin_now[0];
   assign sin_s = pin_now[1];
   assign latch_s = pin_now[2];
   assign ed_s_n = pin_now[3];
   assign ok_s = pin_now[11:4];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_prev <= 1'b0;
         latch_prev <= 1'b0;
         ed_prev_n <= 1'b1;
      end else if (ce) begin
         sclk_prev <= sclk_s;
         latch_prev <= latch_s;
         ed_prev_n <= ed_s_n;
      end
   end

   logic sclk_rise;
   logic latch_rise;
   assign sclk_rise = rose(sclk_prev, sclk_s);
   assign latch_rise = rose(latch_prev, latch_s);

   // ------------------------------------------------------------
   // control state
   // ------------------------------------------------------------
   logic special_mode;
   logic [7:0] shift_q;
   logic [7:0] out_latch;
   logic [7:0] scan_result;
   logic [lsg_pkg::EVT_W-1:0] irq_status;
   logic [lsg_pkg::EVT_W-1:0] irq_mask;
   logic [lsg_pkg::EVT_W-1:0] events;
   lsg_pkg::lsg_det_type det_state;
   lsg_pkg::lsg_det_type next_det_state;
   logic [7:0] settle_cnt;
   logic capture;
   logic [7:0] captured;

   lsg_cfg_if cfg_bus ();

   lsg_gain u_gain (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .cfg(cfg_bus.gain)
   );

   assign current_ratio = cfg_bus.current_ratio;
   assign gain_num = cfg_bus.gain_num;
   assign gain_den = cfg_bus.gain_den;

   // ------------------------------------------------------------
   // error detection sequence
   // ------------------------------------------------------------
   // a detection edge never shifts: the shift input is on the comparators
   always_comb begin
      next_det_state = det_state;
      capture = 1'b0;
      case (det_state)
         lsg_pkg::DET_IDLE: begin
            if (special_mode && !ed_s_n && sclk_rise) begin
               next_det_state = lsg_pkg::DET_SWITCH;
            end
         end
         lsg_pkg::DET_SWITCH: begin
            if (ed_s_n) begin
               next_det_state = lsg_pkg::DET_IDLE;
            end else if (sclk_rise) begin
               next_det_state = lsg_pkg::DET_SETTLE;
            end
         end
         lsg_pkg::DET_SETTLE: begin
            if (ed_s_n) begin
               next_det_state = lsg_pkg::DET_IDLE;
            end else if (sclk_rise) begin
               next_det_state = lsg_pkg::DET_DONE;
               capture = 1'b1;
            end
         end
         lsg_pkg::DET_DONE: begin
            if (ed_s_n) begin
               next_det_state = lsg_pkg::DET_IDLE;
            end
         end
         default: begin
            next_det_state = lsg_pkg::DET_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         det_state <= lsg_pkg::DET_IDLE;
      end else if (ce) begin
         det_state <= next_det_state;
      end
   end

   // measures settle time; a capture before it elapses is flagged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_cnt <= 8'h00;
      end else if (ce) begin
         if (det_state != lsg_pkg::DET_SETTLE) begin
            settle_cnt <= 8'h00;
         end else if (settle_cnt != 8'(lsg_pkg::SETTLE_CYC)) begin
            settle_cnt <= settle_cnt + 8'h01;
         end
      end
   end

   // enabled and at threshold reads one, anything else reads zero
   assign captured = out_latch & ok_s;

   // ------------------------------------------------------------
   // shift register and latches
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_q <= 8'h00;
      end else if (ce) begin
         if (capture) begin
            shift_q <= captured;
         end else if (sclk_rise && det_state == lsg_pkg::DET_IDLE
                      && !(special_mode && !ed_s_n)) begin
            shift_q <= {shift_q[6:0], sin_s};
         end
      end
   end

   // last bit of the register is the chain output to the next device
   assign serial_out = shift_q[7];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_bus.cfg_code <= lsg_pkg::CFG_RESET;
         out_latch <= 8'h00;
      end else if (ce && latch_rise) begin
         if (special_mode) begin
            cfg_bus.cfg_code <= shift_q;
         end else begin
            out_latch <= shift_q;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_result <= 8'h00;
         channel_drive <= 8'h00;
      end else if (ce) begin
         if (capture) begin
            scan_result <= captured;
         end
         channel_drive <= ed_s_n ? 8'h00 : out_latch;
      end
   end

   // ------------------------------------------------------------
   // interrupt events
   // ------------------------------------------------------------
   always_comb begin
      events = '0;
      events[lsg_pkg::EVT_CFG_WRITTEN] = ce & latch_rise & special_mode;
      events[lsg_pkg::EVT_CAPTURED] = ce & capture;
      events[lsg_pkg::EVT_FAULT] = ce & capture & (captured != out_latch);
      events[lsg_pkg::EVT_EARLY] =
         ce & capture & (settle_cnt != 8'(lsg_pkg::SETTLE_CYC));
   end

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lsg_pkg::RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == lsg_pkg::ADDR_CONTROL
                            || aw_addr == lsg_pkg::ADDR_IRQ_MASK)
                           ? lsg_pkg::RESP_OKAY : lsg_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         special_mode <= 1'b0;
         irq_mask <= '0;
      end else if (ce && do_write && w_strb[0]) begin
         if (aw_addr == lsg_pkg::ADDR_CONTROL) begin
            special_mode <= w_data[lsg_pkg::CTRL_SPECIAL_BIT];
         end
         if (aw_addr == lsg_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= w_data[lsg_pkg::EVT_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   logic rd_take;
   logic status_read;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_take = s_axi_arvalid && s_axi_arready && ce;
   assign status_read = rd_take && s_axi_araddr == lsg_pkg::ADDR_IRQ_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= lsg_pkg::RESP_OKAY;
      end else if (ce) begin
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= lsg_pkg::RESP_OKAY;
            case (s_axi_araddr)
               lsg_pkg::ADDR_CONTROL:
                  s_axi_rdata <= {31'h0, special_mode};
               lsg_pkg::ADDR_CONFIG:
                  s_axi_rdata <= {24'h0, cfg_bus.cfg_code};
               lsg_pkg::ADDR_SCAN:
                  s_axi_rdata <= {16'h0, shift_q, scan_result};
               lsg_pkg::ADDR_IRQ_STATUS:
                  s_axi_rdata <= {28'h0, irq_status};
               lsg_pkg::ADDR_IRQ_MASK:
                  s_axi_rdata <= {28'h0, irq_mask};
               lsg_pkg::ADDR_OUT_LATCH:
                  s_axi_rdata <= {24'h0, out_latch};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= lsg_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // an event in the clearing cycle survives the read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else if (ce) begin
         irq_status <= (status_read ? '0 : irq_status) | events;
      end
   end

   assign irq = |(irq_status & irq_mask);
endmodule : lsg_top

// ### testbench/lsg_chk.sv
// port assertions for the led sink gain and error scan block
module lsg_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic serial_clk,
   input wire logic serial_out,
   input wire logic latch_mode_pin,
   input wire logic [3:0] current_ratio,
   input wire logic [7:0] gain_num,
   input wire logic [9:0] gain_den,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lat_cnt;
   logic [7:0] clk_cnt;
   logic lat_q;
   logic sclk_q;

   default clocking @(posedge aclk);
   endclocking

   // ------------------------------------------------------------
   // age of the latest pin rise, saturating so idle never wraps
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      lat_q <= latch_mode_pin;
      if (!aresetn)
         lat_cnt <= 8'hff;
      else if (latch_mode_pin && !lat_q)
         lat_cnt <= 8'h00;
      else if (lat_cnt != 8'hff)
         lat_cnt <= lat_cnt + 8'h01;
   end

   always_ff @(posedge aclk) begin
      sclk_q <= serial_clk;
      if (!aresetn)
         clk_cnt <= 8'hff;
      else if (serial_clk && !sclk_q)
         clk_cnt <= 8'h00;
      else if (clk_cnt != 8'hff)
         clk_cnt <= clk_cnt + 8'h01;
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_reset_gain: assert property (
      (!aresetn && ce) [*2] |=> current_ratio == 4'hf &&
      gain_num == 8'hfe && gain_den == 10'h100)
      else $error("gain not at default after reset");
   a_reset_quiet: assert property (
      !aresetn && ce |=> !irq && !serial_out)
      else $error("outputs active in reset");
   a_ratio_high: assert property (disable iff (!aresetn)
      current_ratio == 4'hf |-> gain_den == 10'h100)
      else $error("high ratio with wrong gain scale");
   a_ratio_low: assert property (disable iff (!aresetn)
      current_ratio == 4'h5 |-> gain_den == 10'h300)
      else $error("low ratio with wrong gain scale");
   a_gain_range: assert property (disable iff (!aresetn)
      (current_ratio == 4'hf || current_ratio == 4'h5) &&
      gain_num >= 8'h40 && gain_num <= 8'hfe)
      else $error("gain outside its steps");
   a_cfg_on_latch: assert property (disable iff (!aresetn)
      $changed(gain_num) || $changed(current_ratio) |-> lat_cnt <= 8'h0a)
      else $error("gain moved without a latch pulse");
   a_out_on_clk: assert property (disable iff (!aresetn)
      $changed(serial_out) |-> clk_cnt <= 8'h08)
      else $error("serial out moved without a clock");
   a_irq_clear: assert property (disable iff (!aresetn)
      irq && s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c &&
      lat_cnt > 8'h08 && clk_cnt > 8'h08 |=> !irq)
      else $error("irq held after status read");

   c_irq: cover property ($rose(irq));
   c_low: cover property (current_ratio == 4'h5);
   c_shift: cover property ($changed(serial_out));
endmodule : lsg_chk

bind lsg_top lsg_chk u_chk (.aclk, .aresetn, .ce, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .serial_clk, .serial_out,
   .latch_mode_pin, .current_ratio, .gain_num, .gain_den, .irq);

// ### testbench/lsg_ctrl_model.sv
// display controller driving the shared serial pins of the chain
module lsg_ctrl_model (
   input wire logic aclk,
   input wire logic serial_out,
   output logic serial_clk,
   output logic serial_in,
   output logic latch_mode_pin,
   output logic enable_switch_detect_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_clk = 1'b0;
      serial_in = 1'b0;
      latch_mode_pin = 1'b0;
      enable_switch_detect_pin_n = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge aclk);
   endtask : hold

   // ------------------------------------------------------------
   // one clock pulse; the clock rests low between pulses
   // ------------------------------------------------------------
   task automatic pulse();
      serial_clk <= 1'b1;
      hold(5);
      serial_clk <= 1'b0;
      hold(5);
   endtask : pulse

   // shared bus: clock, latch and enable go to every chained device
   // eight pulses per device, msb first, reading serial out
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         q[i] = serial_out;
         serial_in <= d[i];
         hold(3);
         serial_clk <= 1'b1;
         hold(3);
         // hold time over: show a changed level, not the old bit
         serial_in <= ~d[i];
         hold(2);
         serial_clk <= 1'b0;
         hold(5);
      end
   endtask : xfer

   task automatic latch();
      latch_mode_pin <= 1'b1;
      hold(4);
      latch_mode_pin <= 1'b0;
      hold(8);
   endtask : latch

   // channels stay enabled throughout the scan
   task automatic detect(input int settle);
      enable_switch_detect_pin_n <= 1'b0;
      hold(4);
      pulse();
      pulse();
      hold(settle);
      pulse();
      enable_switch_detect_pin_n <= 1'b1;
      hold(8);
   endtask : detect
endmodule : lsg_ctrl_model

// ### testbench/testbench.sv
// self-checking bench for the led sink gain and error scan block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic serial_clk, serial_in, serial_out, latch_mode_pin;
   logic enable_switch_detect_pin_n;
   logic [7:0] channel_current_ok = 8'hff;
   logic [7:0] channel_drive, gain_num;
   logic [3:0] current_ratio;
   logic [9:0] gain_den;
   logic irq;
   int err_total = 0;
   int tests_run = 0;

   lsg_top DUT (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clk, .serial_in,
      .serial_out, .latch_mode_pin, .enable_switch_detect_pin_n,
      .channel_current_ok, .channel_drive, .current_ratio, .gain_num,
      .gain_den, .irq);
   lsg_ctrl_model u_ctrl (.aclk, .serial_out, .serial_clk, .serial_in,
      .latch_mode_pin, .enable_switch_detect_pin_n);

   initial begin
      forever #4 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, lsg_pkg::RESP_OKAY);
            return;
         end
      end
      err_total++;
      end_sim();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, e);
            chk(s_axi_rresp, er);
            return;
         end
      end
      err_total++;
      end_sim();
   endtask : rd

   // mantissa weight runs from bit 2 (heaviest) to bit 7
   function automatic logic [7:0] exp_num(input logic [7:0] c);
      logic [7:0] d;
      d = {2'h0, c[2], c[3], c[4], c[5], c[6], c[7]};
      return (d + 8'h40) << c[1];
   endfunction : exp_num

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(current_ratio, 4'hf);
      chk(gain_num, 8'hfe);
      chk(channel_drive, 8'h00);
      rd(lsg_pkg::ADDR_CONFIG, 32'hff, lsg_pkg::RESP_OKAY);
      rd(8'h1c, 32'h0, lsg_pkg::RESP_SLVERR);
   endtask : t_reset

   task automatic t_config();
      logic [7:0] tbl [5] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h81};
      logic [7:0] q;
      wr(lsg_pkg::ADDR_CONTROL, 32'h1);
      for (int i = 0; i < 5; i++) begin
         u_ctrl.xfer(tbl[i], q);
         if (i > 0) chk(q, tbl[i - 1]);
         u_ctrl.latch();
         chk(current_ratio, tbl[i][0] ? 4'hf : 4'h5);
         chk(gain_den, tbl[i][0] ? 10'h100 : 10'h300);
         chk(gain_num, exp_num(tbl[i]));
         rd(lsg_pkg::ADDR_CONFIG, {24'h0, tbl[i]}, 2'h0);
         chk(irq, 1'b0);
         rd(lsg_pkg::ADDR_IRQ_STATUS, 32'h1, 2'h0);
      end
      wr(lsg_pkg::ADDR_IRQ_MASK, 32'hf);
      u_ctrl.xfer(8'hff, q);
      u_ctrl.latch();
      chk(irq, 1'b1);
      rd(lsg_pkg::ADDR_IRQ_STATUS, 32'h1, 2'h0);
      chk(irq, 1'b0);
   endtask : t_config

   task automatic t_latch();
      logic [7:0] q;
      wr(lsg_pkg::ADDR_CONTROL, 32'h0);
      u_ctrl.xfer(8'ha5, q);
      u_ctrl.latch();
      rd(lsg_pkg::ADDR_OUT_LATCH, 32'ha5, 2'h0);
      rd(lsg_pkg::ADDR_CONFIG, 32'hff, 2'h0);
   endtask : t_latch

   // three channels fail; enabled healthy ones keep their one
   task automatic t_detect();
      logic [7:0] q;
      u_ctrl.xfer(8'hff, q);
      u_ctrl.latch();
      wr(lsg_pkg::ADDR_CONTROL, 32'h1);
      channel_current_ok <= 8'hb6;
      u_ctrl.detect(260);
      rd(lsg_pkg::ADDR_SCAN, 32'hb6b6, 2'h0);
      u_ctrl.xfer(8'h3c, q);
      chk(q, 8'hb6);
      chk(irq, 1'b1);
      rd(lsg_pkg::ADDR_IRQ_STATUS, 32'h6, 2'h0);
      rd(lsg_pkg::ADDR_CONFIG, 32'hff, 2'h0);
   endtask : t_detect

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_config();
      t_latch();
      t_detect();
      end_sim();
   end
endmodule : testbench
